// ==== sim/pid_position_regulator_assertions.sv ====
// Port checker of the position regulator.
// Assumes a bind to pid_position_regulator; offsets from pid_cfg.svh.
`timescale 1ns/100ps
`include "pid_cfg.svh"

module pid_position_regulator_assertions (
  input wire logic           pclk,
  input wire logic           presetn,
  input wire logic           psel,
  input wire logic           penable,
  input wire logic           pwrite,
  input wire logic [7:0]     paddr,
  input wire logic [31:0]    pwdata,
  input wire logic [31:0]    prdata,
  input wire logic           pready,
  input wire logic           pslverr,
  input wire pid_pkg::word_t velocity_cmd,
  input wire logic           regulating,
  input wire logic           warn_distance
);
  import pid_pkg::*;
  // ******
  // Mirrors of enable and offset
  // ******
  logic       en_r;
  word_t      off_r;
  logic [2:0] calm_r;
  logic       wr_done;
  assign wr_done = psel && penable && pready && pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_r  <= 1'b0;
      off_r <= '0;
    end else if (wr_done && paddr == `OFS_CTRL) begin
      en_r <= pwdata[0];
    end else if (wr_done && paddr == `OFS_VEL_OFFSET) begin
      off_r <= pwdata;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      calm_r <= 3'h0;
    end else if (en_r || (wr_done && paddr == `OFS_VEL_OFFSET)) begin
      calm_r <= 3'h0;
    end else if (calm_r != 3'h7) begin
      calm_r <= calm_r + 3'h1;
    end
  end
  // ******
  // Properties
  // ******
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_PREADY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_ACCESS_TWO: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("access phase not two cycles");
  AST_ERR_UNMAPPED: assert property (pready && paddr > 8'h34 |-> pslverr)
    else $error("unmapped access without error");
  AST_NO_ERR_MAPPED: assert property (pready && paddr <= 8'h34 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access with error");
  AST_READ_ZERO: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  AST_OFF_VEL: assert property (calm_r >= 3'h3 |-> velocity_cmd == off_r)
    else $error("idle velocity differs from offset");
  AST_RUN_NEEDS_EN: assert property (regulating |-> en_r || $past(en_r) || $past(en_r, 2))
    else $error("regulating while disabled");
  AST_WARN_NEEDS_EN: assert property (warn_distance |-> en_r || $past(en_r) || $past(en_r, 2))
    else $error("warning while disabled");
  AST_RUN_ON_ENABLE: assert property ($rose(en_r) |-> ##[0:2] regulating)
    else $error("no regulation after enable");
endmodule // pid_position_regulator_assertions

// ==== sim/pid_position_regulator_tb.sv ====
// Self-checking bench of the position regulator over APB.
// Assumes pid_pkg, pid_cfg.svh, the model and the checker compiled first.
`timescale 1ns/100ps
`include "pid_cfg.svh"

module pid_position_regulator_tb;
  import pid_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0]  pstrb = 4'hF;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  word_t       enc_set = '0;
  word_t       seq_set = '0;
  word_t       enc_position;
  word_t       seq_position;
  word_t       velocity_cmd;
  logic        regulating;
  logic        warn_distance;
  logic [31:0] rd_data;
  logic [31:0] rd_a;
  logic        rd_err;
  int          n_mismatch = 0;
  int          tests_run = 0;

  pid_position_regulator u_pid_position_regulator (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .enc_position(enc_position), .seq_position(seq_position),
    .velocity_cmd(velocity_cmd), .regulating(regulating), .warn_distance(warn_distance));
  pos_source_model u_pos_source_model (
    .pclk(pclk), .presetn(presetn), .enc_set(enc_set), .seq_set(seq_set),
    .enc_position(enc_position), .seq_position(seq_position));

  initial begin
    forever #5 pclk = ~pclk;
  end
  // ******
  // Bus and compare tasks
  // ******
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) n_mismatch++;
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic setpos(input word_t e, input word_t s);
    @(posedge pclk);
    enc_set <= e;
    seq_set <= s;
    repeat (4) @(posedge pclk);
  endtask
  task automatic print_verdict;
    if (n_mismatch == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ******
  // Scenarios
  // ******
  task automatic t_regs;
    apb(1'b0, `OFS_UPDATE_DIV, 32'h0000_0000);
    chk(rd_data, 32'h0000_00A0);
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk(32'(rd_err), 32'h0000_0001);
    apb(1'b1, `OFS_ERROR, 32'h0000_0005);
    apb(1'b0, `OFS_ERROR, 32'h0000_0000);
    chk(rd_data, 32'h0000_0000);
  endtask
  task automatic t_error;
    setpos(32'h0000_03E8, 32'h0000_0190);
    apb(1'b1, `OFS_CTRL, 32'h0000_0001);
    apb(1'b0, `OFS_ERROR, 32'h0000_0000);
    chk(rd_data, 32'h0000_0258);
    setpos(32'h0000_0064, 32'h0000_012C);
    apb(1'b0, `OFS_ERROR, 32'h0000_0000);
    chk(rd_data, 32'hFFFF_FF38);
    setpos(32'h7FFF_FFFF, 32'hFFFF_FFFF);
    apb(1'b0, `OFS_ERROR, 32'h0000_0000);
    chk(rd_data, 32'h7FFF_FFFF);
    apb(1'b1, `OFS_CTRL, 32'h0000_0000);
  endtask
  task automatic t_pure_p;
    apb(1'b1, `OFS_PROP_GAIN, 32'h0000_0100);
    apb(1'b1, `OFS_UPDATE_DIV, 32'h0000_0002);
    apb(1'b1, `OFS_VEL_OFFSET, 32'h0000_0005);
    setpos(32'h0000_0258, 32'h0000_0000);
    apb(1'b1, `OFS_CTRL, 32'h0000_0001);
    repeat (20) @(posedge pclk);
    apb(1'b0, `OFS_VELOCITY, 32'h0000_0000);
    chk(rd_data, 32'h0000_0258);
    chk(velocity_cmd, 32'h0000_025D);
    chk(32'(regulating), 32'h0000_0001);
    apb(1'b1, `OFS_CTRL, 32'h0000_0000);
  endtask
  task automatic t_integral;
    apb(1'b1, `OFS_PROP_GAIN, 32'h0000_0000);
    apb(1'b1, `OFS_INTEG_GAIN, 32'h0000_0100);
    apb(1'b1, `OFS_INTEG_CLIP, 32'h0000_03E8);
    setpos(32'h0000_000A, 32'h0000_0000);
    apb(1'b1, `OFS_CTRL, 32'h0000_0001);
    apb(1'b0, `OFS_INTEG_SUM, 32'h0000_0000);
    rd_a = rd_data;
    repeat (124) @(posedge pclk);
    apb(1'b0, `OFS_INTEG_SUM, 32'h0000_0000);
    chk(rd_data - rd_a, 32'h0000_000A);
    apb(1'b1, `OFS_INTEG_CLIP, 32'h0000_0019);
    repeat (300) @(posedge pclk);
    apb(1'b0, `OFS_INTEG_SUM, 32'h0000_0000);
    chk(rd_data, 32'h0000_0019);
    apb(1'b0, `OFS_CLIP_AMT, 32'h0000_0000);
    chk(rd_data, 32'h0000_0005);
    apb(1'b1, `OFS_CTRL, 32'h0000_0000);
    apb(1'b0, `OFS_INTEG_SUM, 32'h0000_0000);
    chk(rd_data, 32'h0000_0000);
  endtask
  task automatic t_tol;
    apb(1'b1, `OFS_INTEG_GAIN, 32'h0000_0000);
    apb(1'b1, `OFS_TOLERANCE, 32'h0000_0014);
    apb(1'b1, `OFS_WARN_DIST, 32'h0000_000F);
    setpos(32'h0000_000A, 32'h0000_0000);
    apb(1'b1, `OFS_CTRL, 32'h0000_0001);
    repeat (5) @(posedge pclk);
    chk(32'(regulating), 32'h0000_0000);
    chk(32'(warn_distance), 32'h0000_0000);
    setpos(32'h0000_001E, 32'h0000_0000);
    chk(32'(regulating), 32'h0000_0001);
    chk(32'(warn_distance), 32'h0000_0001);
    apb(1'b1, `OFS_CTRL, 32'h0000_0000);
    repeat (3) @(posedge pclk);
    chk(32'(warn_distance), 32'h0000_0000);
  endtask
  task automatic t_deriv;
    logic seen;
    seen = 1'b0;
    apb(1'b1, `OFS_TOLERANCE, 32'h0000_0000);
    apb(1'b1, `OFS_DERIV_GAIN, 32'h0000_0100);
    setpos(32'h0000_0064, 32'h0000_0000);
    apb(1'b1, `OFS_CTRL, 32'h0000_0001);
    repeat (12) begin
      @(posedge pclk);
      if (velocity_cmd === 32'h0000_0069) seen = 1'b1;
    end
    chk(32'(seen), 32'h0000_0001);
    chk(velocity_cmd, 32'h0000_0005);
    apb(1'b1, `OFS_CTRL, 32'h0000_0000);
  endtask

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_error();
    t_pure_p();
    t_integral();
    t_tol();
    t_deriv();
    print_verdict();
  end
  initial begin
    #200000;
    n_mismatch++;
    print_verdict();
  end
endmodule // pid_position_regulator_tb

bind pid_position_regulator pid_position_regulator_assertions u_pid_position_regulator_assertions (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .velocity_cmd(velocity_cmd), .regulating(regulating), .warn_distance(warn_distance));

// ==== sim/pos_source_model.sv ====
// Model of encoder interface and sequencer: registered positions.
// Assumes the bench sets target positions on pclk.
`timescale 1ns/100ps

module pos_source_model (
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire pid_pkg::word_t enc_set,
  input  wire pid_pkg::word_t seq_set,
  output pid_pkg::word_t      enc_position,
  output pid_pkg::word_t      seq_position
);
  import pid_pkg::*;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enc_position <= '0;
      seq_position <= '0;
    end else begin
      enc_position <= enc_set;
      seq_position <= seq_set;
    end
  end
endmodule // pos_source_model

// ==== src/pid_cfg.svh ====
// Constants of the position regulator: offsets, reset values, timing.
// Assumes inclusion by bare name from the package and the modules.
`ifndef PID_CFG_SVH
`define PID_CFG_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define OFS_CTRL        8'h00
`define OFS_PROP_GAIN   8'h04
`define OFS_INTEG_GAIN  8'h08
`define OFS_DERIV_GAIN  8'h0C
`define OFS_INTEG_CLIP  8'h10
`define OFS_TOLERANCE   8'h14
`define OFS_UPDATE_DIV  8'h18
`define OFS_VEL_OFFSET  8'h1C
`define OFS_ERROR       8'h20
`define OFS_CLIP_AMT    8'h24
`define OFS_VELOCITY    8'h28
`define OFS_INTEG_SUM   8'h2C
`define OFS_WARN_DIST   8'h30
`define OFS_STATUS      8'h34

// ****************************************
// Field positions
// ****************************************
`define CTRL_ENABLE_BIT 0
`define STAT_REG_BIT    0
`define STAT_WARN_BIT   1

// ****************************************
// Reset values
// ****************************************
`define GAIN_RST        16'h0000
`define CLIP_RST        31'h0000_0000
`define TOL_RST         32'h0000_0000
`define UPD_DIV_RST     16'h00A0
`define WORD_RST        32'h0000_0000

// ****************************************
// Timing and scaling
// ****************************************
`define INTEG_DIV       128
`define GAIN_SHIFT      8

`endif

// ==== src/pid_pkg.sv ====
// Types of the position regulator.
// Assumes pid_cfg.svh beside it.
`include "pid_cfg.svh"

package pid_pkg;

  typedef logic signed [31:0] word_t;
  typedef logic signed [15:0] gain_t;

  // Regulator state, Gray coded along off -> run -> hold
  typedef enum logic [1:0] {
    REG_OFF  = 2'b00,
    REG_RUN  = 2'b01,
    REG_HOLD = 2'b11
  } reg_state_t;

endpackage

// ==== src/pid_position_regulator.sv ====
// Closed-loop position regulator with APB register access.
// Assumes encoder and sequencer positions come from logic on pclk.
//
// Operation
// - Error is encoder position minus sequencer position; velocity derives from it.
// - Velocity is P times error plus integral sum plus D times error change.
// - Regulation holds once error magnitude is below tolerance, avoiding oscillation.
// - Zero derivative gain gives PI; zero integral gain too gives pure P.
// - Host velocity offset is added to the regulator velocity output.
// - Amount of clipping currently applied is readable.
// - Integral sum is limited to a programmable clip value.
// - Each integration step adds integral gain times error, within clip.
// - Current position error is readable while enabled; it reads zero while the regulator is disabled.
// - Integration steps occur at clock divided by 128.
// - Derivative time base is set by a programmable divider.
// - Update rate is programmable, fast enough to regulate during motion.
// - Warning distance compare uses regulator error, needs regulator enabled.
`timescale 1ns/100ps
`include "pid_cfg.svh"

module pid_position_regulator #(
  parameter int INTEG_DIV = `INTEG_DIV
) (
  input  wire  logic           pclk,
  input  wire  logic           presetn,
  input  wire  logic           psel,
  input  wire  logic           penable,
  input  wire  logic           pwrite,
  input  wire  logic [7:0]     paddr,
  input  wire  logic [31:0]    pwdata,
  input  wire  logic [3:0]     pstrb,
  output logic [31:0]          prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire  pid_pkg::word_t enc_position,
  input  wire  pid_pkg::word_t seq_position,
  output pid_pkg::word_t       velocity_cmd,
  output logic                 regulating,
  output logic                 warn_distance
);
  import pid_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  logic        enable_r;
  gain_t       prop_gain_r;
  gain_t       integ_gain_r;
  gain_t       deriv_gain_r;
  logic [30:0] integ_clip_r;
  logic [31:0] tolerance_r;
  logic [15:0] update_div_r;
  word_t       host_velocity_offset_r;
  logic [31:0] warn_dist_r;
  word_t       error_r;
  word_t       error_prev_r;
  word_t       integ_sum_r;
  word_t       clipping_amount_r;
  word_t       deriv_term_r;
  word_t       velocity_r;
  reg_state_t  state_r;
  reg_state_t  state_nxt;
  logic [6:0]  integ_cnt_r;
  logic [15:0] update_cnt_r;
  logic        integ_tick;
  logic        update_tick;
  logic        wr_en;
  logic        rd_en;
  logic        mapped;
  logic [31:0] rd_data;
  logic [31:0] wmask;
  logic [32:0] diff33;
  word_t       error_nxt;
  logic [31:0] err_mag;
  word_t       p_term;
  word_t       i_step;
  word_t       d_delta;
  word_t       d_prod;
  logic [32:0] isum33;
  logic [32:0] clip33;
  word_t       isum_nxt;
  word_t       clip_nxt;
  logic [34:0] vel35;
  word_t       vel_nxt;

  // ****************************************
  // Saturating helpers
  // ****************************************
  function automatic word_t sat33(input logic [32:0] v);
    if (v[32] != v[31]) begin
      sat33 = v[32] ? -32'sh8000_0000 : 32'sh7FFF_FFFF;
    end else begin
      sat33 = v[31:0];
    end
  endfunction

  function automatic word_t sat35(input logic [34:0] v);
    if ($signed(v) > 35'sh0_7FFF_FFFF) begin
      sat35 = 32'sh7FFF_FFFF;
    end else if ($signed(v) < -35'sh0_8000_0000) begin
      sat35 = -32'sh8000_0000;
    end else begin
      sat35 = v[31:0];
    end
  endfunction

  // ****************************************
  // APB slave
  // ****************************************
  assign wr_en = psel & penable & pready & pwrite;
  assign rd_en = psel & penable & ~pready & ~pwrite;

  generate
    for (genvar b = 0; b < 4; b++) begin : g_mask
      assign wmask[8*b +: 8] = {8{pstrb[b]}};
    end
  endgenerate

  always_comb begin
    mapped  = 1'b1;
    rd_data = `WORD_RST;
    if (paddr == `OFS_CTRL) begin
      rd_data[`CTRL_ENABLE_BIT] = enable_r;
    end else if (paddr == `OFS_PROP_GAIN) begin
      rd_data = {{16{prop_gain_r[15]}}, prop_gain_r};
    end else if (paddr == `OFS_INTEG_GAIN) begin
      rd_data = {{16{integ_gain_r[15]}}, integ_gain_r};
    end else if (paddr == `OFS_DERIV_GAIN) begin
      rd_data = {{16{deriv_gain_r[15]}}, deriv_gain_r};
    end else if (paddr == `OFS_INTEG_CLIP) begin
      rd_data = {1'b0, integ_clip_r};
    end else if (paddr == `OFS_TOLERANCE) begin
      rd_data = tolerance_r;
    end else if (paddr == `OFS_UPDATE_DIV) begin
      rd_data = {16'h0000, update_div_r};
    end else if (paddr == `OFS_VEL_OFFSET) begin
      rd_data = host_velocity_offset_r;
    end else if (paddr == `OFS_ERROR) begin
      rd_data = error_r;
    end else if (paddr == `OFS_CLIP_AMT) begin
      rd_data = clipping_amount_r;
    end else if (paddr == `OFS_VELOCITY) begin
      rd_data = velocity_r;
    end else if (paddr == `OFS_INTEG_SUM) begin
      rd_data = integ_sum_r;
    end else if (paddr == `OFS_WARN_DIST) begin
      rd_data = warn_dist_r;
    end else if (paddr == `OFS_STATUS) begin
      rd_data[`STAT_REG_BIT]  = regulating;
      rd_data[`STAT_WARN_BIT] = warn_distance;
    end else begin
      mapped = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `WORD_RST;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      if (rd_en) begin
        prdata <= mapped ? rd_data : `WORD_RST;
      end
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_r               <= 1'b0;
      prop_gain_r            <= `GAIN_RST;
      integ_gain_r           <= `GAIN_RST;
      deriv_gain_r           <= `GAIN_RST;
      integ_clip_r           <= `CLIP_RST;
      tolerance_r            <= `TOL_RST;
      update_div_r           <= `UPD_DIV_RST;
      host_velocity_offset_r <= `WORD_RST;
      warn_dist_r            <= `WORD_RST;
    end else if (wr_en) begin
      if (paddr == `OFS_CTRL) begin
        if (pstrb[0]) begin
          enable_r <= pwdata[`CTRL_ENABLE_BIT];
        end
      end else if (paddr == `OFS_PROP_GAIN) begin
        prop_gain_r <= (prop_gain_r & ~wmask[15:0]) | (pwdata[15:0] & wmask[15:0]);
      end else if (paddr == `OFS_INTEG_GAIN) begin
        integ_gain_r <= (integ_gain_r & ~wmask[15:0]) | (pwdata[15:0] & wmask[15:0]);
      end else if (paddr == `OFS_DERIV_GAIN) begin
        deriv_gain_r <= (deriv_gain_r & ~wmask[15:0]) | (pwdata[15:0] & wmask[15:0]);
      end else if (paddr == `OFS_INTEG_CLIP) begin
        integ_clip_r <= (integ_clip_r & ~wmask[30:0]) | (pwdata[30:0] & wmask[30:0]);
      end else if (paddr == `OFS_TOLERANCE) begin
        tolerance_r <= (tolerance_r & ~wmask) | (pwdata & wmask);
      end else if (paddr == `OFS_UPDATE_DIV) begin
        update_div_r <= (update_div_r & ~wmask[15:0]) | (pwdata[15:0] & wmask[15:0]);
      end else if (paddr == `OFS_VEL_OFFSET) begin
        host_velocity_offset_r <= (host_velocity_offset_r & ~wmask) | (pwdata & wmask);
      end else if (paddr == `OFS_WARN_DIST) begin
        warn_dist_r <= (warn_dist_r & ~wmask) | (pwdata & wmask);
      end
    end
  end

  // ****************************************
  // Time bases
  // ****************************************
  assign integ_tick  = enable_r && (integ_cnt_r == 7'(INTEG_DIV - 1));
  assign update_tick = enable_r && (update_cnt_r >= update_div_r);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      integ_cnt_r <= 7'h00;
    end else if (!enable_r || integ_tick) begin
      integ_cnt_r <= 7'h00;
    end else begin
      integ_cnt_r <= integ_cnt_r + 7'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      update_cnt_r <= 16'h0000;
    end else if (!enable_r || update_tick) begin
      update_cnt_r <= 16'h0000;
    end else begin
      update_cnt_r <= update_cnt_r + 16'h0001;
    end
  end

  // ****************************************
  // Position error
  // ****************************************
  assign diff33    = {enc_position[31], enc_position} - {seq_position[31], seq_position};
  assign error_nxt = sat33(diff33);
  assign err_mag   = error_r[31] ? 32'(-error_r) : error_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      error_r <= `WORD_RST;
    end else begin
      error_r <= enable_r ? error_nxt : `WORD_RST;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warn_distance <= 1'b0;
    end else begin
      warn_distance <= enable_r && (err_mag > warn_dist_r);
    end
  end

  // ****************************************
  // Regulation state with tolerance hysteresis
  // ****************************************
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      REG_OFF: begin
        if (enable_r) begin
          state_nxt = REG_RUN;
        end
      end
      REG_RUN: begin
        if (!enable_r) begin
          state_nxt = REG_OFF;
        end else if (err_mag < tolerance_r) begin
          state_nxt = REG_HOLD;
        end
      end
      REG_HOLD: begin
        if (!enable_r) begin
          state_nxt = REG_OFF;
        end else if (err_mag > tolerance_r) begin
          state_nxt = REG_RUN;
        end
      end
      default: begin
        state_nxt = REG_OFF;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r    <= REG_OFF;
      regulating <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      regulating <= (state_nxt == REG_RUN);
    end
  end

  // ****************************************
  // Gain products
  // ****************************************
  sat_mac u_prop (
    .value  (error_r),
    .gain   (prop_gain_r),
    .result (p_term)
  );

  sat_mac u_integ (
    .value  (error_r),
    .gain   (integ_gain_r),
    .result (i_step)
  );

  assign d_delta = sat33({error_r[31], error_r} - {error_prev_r[31], error_prev_r});

  sat_mac u_deriv (
    .value  (d_delta),
    .gain   (deriv_gain_r),
    .result (d_prod)
  );

  // ****************************************
  // Integral accumulator with clipping
  // ****************************************
  assign isum33 = {integ_sum_r[31], integ_sum_r} + {i_step[31], i_step};
  assign clip33 = {2'b00, integ_clip_r};

  always_comb begin
    if ($signed(isum33) > $signed(clip33)) begin
      isum_nxt = {1'b0, integ_clip_r};
    end else if ($signed(isum33) < -$signed(clip33)) begin
      isum_nxt = 32'(-$signed({1'b0, integ_clip_r}));
    end else begin
      isum_nxt = isum33[31:0];
    end
    clip_nxt = sat33(isum33 - {isum_nxt[31], isum_nxt});
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      integ_sum_r       <= `WORD_RST;
      clipping_amount_r <= `WORD_RST;
    end else if (!enable_r) begin
      integ_sum_r       <= `WORD_RST;
      clipping_amount_r <= `WORD_RST;
    end else if (integ_tick && state_r == REG_RUN) begin
      integ_sum_r       <= isum_nxt;
      clipping_amount_r <= clip_nxt;
    end
  end

  // ****************************************
  // Derivative and velocity update
  // ****************************************
  assign vel35 = {{3{p_term[31]}}, p_term} + {{3{integ_sum_r[31]}}, integ_sum_r}
               + {{3{deriv_term_r[31]}}, deriv_term_r};
  assign vel_nxt = sat35(vel35);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      error_prev_r <= `WORD_RST;
      deriv_term_r <= `WORD_RST;
    end else if (!enable_r) begin
      error_prev_r <= `WORD_RST;
      deriv_term_r <= `WORD_RST;
    end else if (update_tick) begin
      error_prev_r <= error_r;
      deriv_term_r <= d_prod;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      velocity_r <= `WORD_RST;
    end else if (state_r != REG_RUN) begin
      velocity_r <= `WORD_RST;
    end else if (update_tick) begin
      velocity_r <= vel_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      velocity_cmd <= `WORD_RST;
    end else begin
      velocity_cmd <= sat33({velocity_r[31], velocity_r}
                    + {host_velocity_offset_r[31], host_velocity_offset_r});
    end
  end

endmodule // pid_position_regulator

// ==== src/sat_mac.sv ====
// Signed gain multiplier with scaling and saturation to one word.
// Assumes a purely combinational use on the regulator clock.
`timescale 1ns/100ps
`include "pid_cfg.svh"

module sat_mac #(
  parameter int SHIFT = `GAIN_SHIFT
) (
  input  wire  pid_pkg::word_t value,
  input  wire  pid_pkg::gain_t gain,
  output pid_pkg::word_t       result
);
  import pid_pkg::*;

  logic signed [47:0] prod;
  logic signed [47:0] scaled;

  // ****************************************
  // Multiply, scale, saturate
  // ****************************************
  always_comb begin
    prod   = value * gain;
    scaled = prod >>> SHIFT;
    if (scaled > 48'sh0000_7FFF_FFFF) begin
      result = 32'sh7FFF_FFFF;
    end else if (scaled < -48'sh0000_8000_0000) begin
      result = -32'sh8000_0000;
    end else begin
      result = scaled[31:0];
    end
  end

endmodule // sat_mac
